//--- hdl/pix_back_pkg.sv
// Contract
// [R1] alpha test compares pixel alpha to reference with one of eight functions
// [R2] alpha reference is an unsigned eight-bit value spanning zero to one
// [R3] alpha reference resets to zero
// [R4] pixel failing the alpha test is discarded, passing pixel continues
// [R5] dithering reduces 8-bit colour, alpha, fog to five bits, green six
// [R6] four-bit dither value from 4x4 matrix indexed by x and y low bits
// [R7] dither aligned to dropped bits, added, sum truncated to top bits; the code saturates a sum that carries past eight bits to all ones
// [R8] without dithering components are reduced by plain truncation
// [R9] shading mode chosen separately for alpha, fog, specular and colour
// [R10] flat shading uses first vertex value for every pixel
// [R11] smooth shading uses the interpolated per-pixel value
// [R12] stipple enabled: 32x32 mask, zero bit renders the pixel black
// [R13] stipple mask resets to zero, so enabled stipple gives black
// [R14] textures fetched only from system memory over graphics port
// [R15] textures laid out tiled in system memory
package pix_back_pkg;
   // ******************************
   // register map (byte addresses)
   // ******************************
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] AREF_OFS = 8'h04;
   localparam logic [7:0] STAT_OFS = 8'h08;
   localparam logic [7:0] TEXB_OFS = 8'h0C;
   localparam logic [7:0] STIP_OFS = 8'h80;
   localparam logic [7:0] STIP_END = 8'hFC;
   // ******************************
   // control field positions
   // ******************************
   localparam int ATEST_EN_BIT = 0;
   localparam int AFUNC_LSB = 1;
   localparam int DITH_EN_BIT = 4;
   localparam int STIP_EN_BIT = 5;
   localparam int SH_ALPHA_BIT = 6;
   localparam int SH_FOG_BIT = 7;
   localparam int SH_SPEC_BIT = 8;
   localparam int SH_COL_BIT = 9;
   localparam int CTRL_W = 10;
   // ******************************
   // reset values
   // ******************************
   localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
   localparam logic [7:0] AREF_RST = 8'h00;
   localparam logic [31:0] STIP_RST = 32'h0000_0000;
   localparam logic [31:0] TEXB_RST = 32'h0000_0000;
   localparam int TILE_SHIFT = 4;
   typedef enum logic [2:0] {
      CMP_NEVER, CMP_LESS, CMP_EQUAL, CMP_LEQUAL,
      CMP_GREATER, CMP_NOTEQUAL, CMP_GEQUAL, CMP_ALWAYS
   } afunc_t;
endpackage : pix_back_pkg

//--- hdl/dither_unit.sv
`timescale 1ns/100ps
// ******************************
// one-component dither and reduce
// ******************************
module dither_unit #(
   parameter int OUT_W = 5
) (
   input wire logic [7:0] val_i,
   input wire logic [3:0] dith_i,
   input wire logic en_i,
   output logic [OUT_W-1:0] res_o
);
   logic [8:0] sum;
   logic [7:0] add;
   // align dither to the bits that truncation drops
   always_comb begin
      add = en_i ? 8'(({4'h0, dith_i}) >> (OUT_W - 4)) : 8'h00; // R7 R8
      sum = {1'b0, val_i} + {1'b0, add};
      // saturate so a bright value never wraps to dark
      res_o = sum[8] ? {OUT_W{1'b1}} : sum[7 -: OUT_W]; // R7
   end
endmodule : dither_unit

//--- hdl/pix_back.sv
// The Wishbone interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/100ps
// ******************************
// per-pixel back end: shade, alpha test, stipple, dither
// ******************************
module pix_back (
   input wire logic clk_i,
   input wire logic rst_i,
   // classic wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // pixel in from rasterizer
   input wire logic pix_valid_i,
   output logic pix_ready_o,
   input wire logic [9:0] pix_x_i,
   input wire logic [9:0] pix_y_i,
   input wire logic [23:0] smooth_rgb_i,
   input wire logic [7:0] smooth_a_i,
   input wire logic [7:0] smooth_fog_i,
   input wire logic [23:0] smooth_spec_i,
   input wire logic [23:0] flat_rgb_i,
   input wire logic [7:0] flat_a_i,
   input wire logic [7:0] flat_fog_i,
   input wire logic [23:0] flat_spec_i,
   // pixel out to frame buffer writer
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [9:0] out_x_o,
   output logic [9:0] out_y_o,
   output logic [15:0] out_rgb_o,
   output logic [4:0] out_a_o,
   output logic [4:0] out_fog_o,
   output logic [15:0] out_spec_o,
   // texture fetch address toward the graphics port
   input wire logic [7:0] tex_u_i,
   input wire logic [7:0] tex_v_i,
   output logic [31:0] tex_addr_o,
   output logic tex_sysmem_o
);
   import pix_back_pkg::*;

   // ******************************
   // register state
   // ******************************
   // bus side registers and status
   logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;
   logic [7:0] aref_r, aref_nxt;
   logic [31:0] texb_r, texb_nxt;
   logic [31:0] stip_r [32];
   logic [31:0] stip_nxt [32];
   logic ack_r, ack_nxt;
   logic [31:0] rdat_r, rdat_nxt;
   logic [15:0] drop_cnt_r, drop_cnt_nxt;
   logic [15:0] pass_cnt_r, pass_cnt_nxt;
   logic req;
   logic [31:0] wmask;
   logic [4:0] stip_idx;
   logic stip_hit;

   // byte-lane mask from sel
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wmask[i*8 +: 8] = {8{sel_i[i]}};
      end
   end

   // request seen only while ack is low, so ack lasts one cycle
   assign req = cyc_i & stb_i & ~ack_r;
   assign stip_idx = adr_i[6:2];
   assign stip_hit = (adr_i >= STIP_OFS) && (adr_i <= STIP_END);

   // ******************************
   // pixel pipeline signals
   // ******************************
   logic [23:0] rgb_s, spec_s;
   logic [7:0] a_s, fog_s;
   logic a_pass;
   logic stip_bit;
   logic [3:0] dval;
   logic [3:0] dith_mat [16];
   logic blk;
   logic [7:0] r8, g8, b8, sr8, sg8, sb8;
   logic [4:0] r5, b5, a5, f5, sr5, sb5;
   logic [5:0] g6, sg6;
   logic take;
   // output slot, one pixel deep
   logic ov_r, ov_nxt;
   logic [9:0] ox_r, ox_nxt, oy_r, oy_nxt;
   logic [15:0] orgb_r, orgb_nxt, ospec_r, ospec_nxt;
   logic [4:0] oa_r, oa_nxt, of_r, of_nxt;
   logic [31:0] taddr_r, taddr_nxt;

   // standard ordered bayer pattern
   assign dith_mat = '{4'h0, 4'h8, 4'h2, 4'hA,
                       4'hC, 4'h4, 4'hE, 4'h6,
                       4'h3, 4'hB, 4'h1, 4'h9,
                       4'hF, 4'h7, 4'hD, 4'h5};

   // ******************************
   // register next-state
   // ******************************
   always_comb begin
      ctrl_nxt = ctrl_r;
      aref_nxt = aref_r;
      texb_nxt = texb_r;
      stip_nxt = stip_r;
      ack_nxt = req;
      rdat_nxt = rdat_r;
      drop_cnt_nxt = drop_cnt_r;
      pass_cnt_nxt = pass_cnt_r;
      if (req && we_i) begin
         if (adr_i == CTRL_OFS) begin
            ctrl_nxt = CTRL_W'((ctrl_r & ~wmask[CTRL_W-1:0]) | (dat_i[CTRL_W-1:0] &
               wmask[CTRL_W-1:0]));
         end else if (adr_i == AREF_OFS) begin
            if (sel_i[0]) begin
               aref_nxt = dat_i[7:0]; // R2
            end
         end else if (adr_i == TEXB_OFS) begin
            texb_nxt = (texb_r & ~wmask) | (dat_i & wmask);
         end else if (stip_hit) begin
            stip_nxt[stip_idx] = (stip_r[stip_idx] & ~wmask) | (dat_i & wmask);
         end
      end
      if (req && !we_i) begin
         if (adr_i == CTRL_OFS) begin
            rdat_nxt = {22'h000000, ctrl_r};
         end else if (adr_i == AREF_OFS) begin
            rdat_nxt = {24'h000000, aref_r};
         end else if (adr_i == STAT_OFS) begin
            rdat_nxt = {pass_cnt_r, drop_cnt_r};
         end else if (adr_i == TEXB_OFS) begin
            rdat_nxt = texb_r;
         end else if (stip_hit) begin
            rdat_nxt = stip_r[stip_idx];
         end else begin
            rdat_nxt = 32'h0000_0000; // unmapped reads zero
         end
      end
      // status counters of pixels kept and discarded
      // they wrap at 16 bits; software must sample them often enough
      if (take && ctrl_r[ATEST_EN_BIT] && !a_pass) begin
         drop_cnt_nxt = drop_cnt_r + 16'h0001;
      end
      if (take && (a_pass || !ctrl_r[ATEST_EN_BIT])) begin
         pass_cnt_nxt = pass_cnt_r + 16'h0001;
      end
   end

   // register storage
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_r <= CTRL_RST;
         aref_r <= AREF_RST; // R3
         texb_r <= TEXB_RST;
         for (int i = 0; i < 32; i++) begin
            stip_r[i] <= STIP_RST; // R13
         end
         ack_r <= 1'b0;
         rdat_r <= 32'h0000_0000;
         drop_cnt_r <= 16'h0000;
         pass_cnt_r <= 16'h0000;
      end else begin
         ctrl_r <= ctrl_nxt;
         aref_r <= aref_nxt;
         texb_r <= texb_nxt;
         stip_r <= stip_nxt;
         ack_r <= ack_nxt;
         rdat_r <= rdat_nxt;
         drop_cnt_r <= drop_cnt_nxt;
         pass_cnt_r <= pass_cnt_nxt;
      end
   end

   assign ack_o = ack_r;
   assign dat_o = rdat_r;

   // ******************************
   // shading select per attribute
   // ******************************
   // flat values are the first vertex attributes, held for the whole triangle
   always_comb begin
      a_s = ctrl_r[SH_ALPHA_BIT] ? smooth_a_i : flat_a_i; // R9 R10 R11
      fog_s = ctrl_r[SH_FOG_BIT] ? smooth_fog_i : flat_fog_i; // R9 R10 R11
      spec_s = ctrl_r[SH_SPEC_BIT] ? smooth_spec_i : flat_spec_i; // R9 R10 R11
      rgb_s = ctrl_r[SH_COL_BIT] ? smooth_rgb_i : flat_rgb_i; // R9 R10 R11
   end

   // ******************************
   // alpha test
   // ******************************
   // unsigned compare against the full eight-bit reference
   always_comb begin
      case (afunc_t'(ctrl_r[AFUNC_LSB +: 3])) // R1
         CMP_NEVER: a_pass = 1'b0;
         CMP_LESS: a_pass = a_s < aref_r;
         CMP_EQUAL: a_pass = a_s == aref_r;
         CMP_LEQUAL: a_pass = a_s <= aref_r;
         CMP_GREATER: a_pass = a_s > aref_r;
         CMP_NOTEQUAL: a_pass = a_s != aref_r;
         CMP_GEQUAL: a_pass = a_s >= aref_r;
         default: a_pass = 1'b1;
      endcase
   end

   // ******************************
   // stipple and dither lookup
   // ******************************
   // mask row by y, bit by x; the pattern repeats every 32 pixels
   assign stip_bit = stip_r[pix_y_i[4:0]][pix_x_i[4:0]];
   assign blk = ctrl_r[STIP_EN_BIT] & ~stip_bit; // R12
   assign dval = dith_mat[{pix_y_i[1:0], pix_x_i[1:0]}]; // R6

   // black forced before reduction so the dither cannot lift it
   always_comb begin
      r8 = blk ? 8'h00 : rgb_s[23:16];
      g8 = blk ? 8'h00 : rgb_s[15:8];
      b8 = blk ? 8'h00 : rgb_s[7:0];
      sr8 = blk ? 8'h00 : spec_s[23:16];
      sg8 = blk ? 8'h00 : spec_s[15:8];
      sb8 = blk ? 8'h00 : spec_s[7:0];
   end

   // one reducer per five-bit component
   logic [7:0] c5_in [6];
   logic [4:0] c5_out [6];
   logic [3:0] dq;
   assign dq = blk ? 4'h0 : dval;
   assign c5_in = '{r8, b8, a_s, fog_s, sr8, sb8};
   generate
      for (genvar k = 0; k < 6; k++) begin : g_c5
         dither_unit #(
            .OUT_W(5)
         ) u_d5 (
            .val_i(c5_in[k]),
            .dith_i(dq),
            .en_i(ctrl_r[DITH_EN_BIT]), // R5 R8
            .res_o(c5_out[k])
         );
      end
   endgenerate
   // unpack the reducer outputs in the order they were packed
   assign r5 = c5_out[0];
   assign b5 = c5_out[1];
   assign a5 = c5_out[2];
   assign f5 = c5_out[3];
   assign sr5 = c5_out[4];
   assign sb5 = c5_out[5];

   // green keeps six bits
   dither_unit #(
      .OUT_W(6)
   ) u_dg (
      .val_i(g8),
      .dith_i(dq),
      .en_i(ctrl_r[DITH_EN_BIT]), // R5
      .res_o(g6)
   );
   // specular green keeps six bits like the colour green
   dither_unit #(
      .OUT_W(6)
   ) u_dsg (
      .val_i(sg8),
      .dith_i(dq),
      .en_i(ctrl_r[DITH_EN_BIT]), // R5
      .res_o(sg6)
   );

   // ******************************
   // output stage
   // ******************************
   // ready is combinational so a draining slot refills in the same cycle
   assign pix_ready_o = ~ov_r | out_ready_i;
   assign take = pix_valid_i & pix_ready_o;

   // next values of the output slot
   always_comb begin
      ov_nxt = ov_r & ~out_ready_i;
      ox_nxt = ox_r;
      oy_nxt = oy_r;
      orgb_nxt = orgb_r;
      ospec_nxt = ospec_r;
      oa_nxt = oa_r;
      of_nxt = of_r;
      taddr_nxt = taddr_r;
      if (take) begin
         // a failing pixel is consumed but never presented
         ov_nxt = a_pass | ~ctrl_r[ATEST_EN_BIT]; // R4
         ox_nxt = pix_x_i;
         oy_nxt = pix_y_i;
         orgb_nxt = {r5, g6, b5};
         ospec_nxt = {sr5, sg6, sb5};
         oa_nxt = a5;
         of_nxt = f5;
         // tiled layout: 16x16 texel tiles laid out contiguously, so one tile
         // sits in one memory page and neighbouring texels seldom miss
         taddr_nxt = texb_r + 32'({tex_v_i[7:TILE_SHIFT],
            tex_u_i[7:TILE_SHIFT],
            tex_v_i[TILE_SHIFT-1:0],
            tex_u_i[TILE_SHIFT-1:0],
            1'b0}); // R15
      end
   end

   // output slot registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ov_r <= 1'b0;
         ox_r <= 10'h000;
         oy_r <= 10'h000;
         orgb_r <= 16'h0000;
         ospec_r <= 16'h0000;
         oa_r <= 5'h00;
         of_r <= 5'h00;
         taddr_r <= 32'h0000_0000;
      end else begin
         ov_r <= ov_nxt;
         ox_r <= ox_nxt;
         oy_r <= oy_nxt;
         orgb_r <= orgb_nxt;
         ospec_r <= ospec_nxt;
         oa_r <= oa_nxt;
         of_r <= of_nxt;
         taddr_r <= taddr_nxt;
      end
   end

   // data outputs come straight from the slot flops
   assign out_valid_o = ov_r;
   assign out_x_o = ox_r;
   assign out_y_o = oy_r;
   assign out_rgb_o = orgb_r;
   assign out_spec_o = ospec_r;
   assign out_a_o = oa_r;
   assign out_fog_o = of_r;
   assign tex_addr_o = taddr_r;
   // no local-memory path exists; fetches always target system memory
   assign tex_sysmem_o = 1'b1; // R14
endmodule : pix_back

//--- testbench/pix_back_props.sv
`timescale 1ns/100ps
// ******************************
// port checker for the pixel back end
// ******************************
module pix_back_props (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic ack_o,
   input wire logic pix_valid_i,
   input wire logic pix_ready_o,
   input wire logic [9:0] pix_x_i,
   input wire logic out_valid_o,
   input wire logic out_ready_i,
   input wire logic [9:0] out_x_o,
   input wire logic [15:0] out_rgb_o,
   input wire logic tex_sysmem_o
);
   import pix_back_pkg::*;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [3:0] ctl_r;
   logic [3:0] ctl_nxt;
   logic acc;
   assign acc = pix_valid_i && pix_ready_o;
   // shadow of test enable and function, taken at the request edge like the block
   always_comb begin
      ctl_nxt = ctl_r;
      if (cyc_i && stb_i && we_i && !ack_o && adr_i == CTRL_OFS && sel_i[0]) begin
         ctl_nxt = dat_i[3:0];
      end
   end
   always_ff @(posedge clk_i) begin
      ctl_r <= rst_i ? 4'h0 : ctl_nxt;
   end
   property p_ack; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
   property p_ack_pulse; ack_o |=> !ack_o; endproperty
   property p_sysmem; tex_sysmem_o; endproperty
   property p_ready; pix_ready_o == (!out_valid_o || out_ready_i); endproperty
   property p_hold; out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_rgb_o); endproperty
   property p_never; acc && ctl_r == 4'h1 |=> !out_valid_o; endproperty
   property p_always;
      acc && (!ctl_r[0] || ctl_r[3:1] == 3'h7) |=> out_valid_o && out_x_o == $past(pix_x_i);
   endproperty
   property p_drain; out_valid_o && out_ready_i && !acc |=> !out_valid_o; endproperty
   a_ack: assert property (p_ack) else $error("ack late");
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   a_sysmem: assert property (p_sysmem) else $error("texture source not system memory");
   a_ready: assert property (p_ready) else $error("ready wrong");
   a_hold: assert property (p_hold) else $error("output changed while stalled");
   a_never: assert property (p_never) else $error("pixel passed a never test");
   a_always: assert property (p_always) else $error("passing pixel lost");
   a_drain: assert property (p_drain) else $error("output valid stuck");
   c_never: cover property (acc && ctl_r == 4'h1);
   c_stall: cover property (out_valid_o && !out_ready_i);
   c_read: cover property (ack_o && !we_i);
endmodule : pix_back_props
bind pix_back pix_back_props props_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
   .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o),
   .pix_valid_i(pix_valid_i), .pix_ready_o(pix_ready_o), .pix_x_i(pix_x_i),
   .out_valid_o(out_valid_o), .out_ready_i(out_ready_i), .out_x_o(out_x_o),
   .out_rgb_o(out_rgb_o), .tex_sysmem_o(tex_sysmem_o));

//--- testbench/pix_sink.sv
`timescale 1ns/100ps
// ******************************
// frame buffer writer model
// ******************************
module pix_sink (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic stall_i,
   output logic ready_o = 1'b1
);
   logic [7:0] lfsr_r = 8'hA5;
   // ready ignores valid, so the stage must hold its output across stalls
   always_ff @(posedge clk_i) begin
      lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
      ready_o <= rst_i || !stall_i || lfsr_r[0];
   end
endmodule : pix_sink

//--- testbench/pix_back_tb.sv
`timescale 1ns/100ps
module pix_back_tb;
   import pix_back_pkg::*;
   typedef struct packed {
      logic blk;
      logic [35:0] xyc;
      logic [25:0] afs;
      logic [31:0] tex;
   } exp_t;
   logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, pix_valid_i = 0, stall = 0;
   logic [7:0] adr_i = 0, tex_u_i = 0, tex_v_i = 0, smooth_a_i = 0, flat_a_i = 0;
   logic [7:0] smooth_fog_i = 0, flat_fog_i = 0;
   logic [23:0] smooth_rgb_i = 0, smooth_spec_i = 0, flat_rgb_i = 0, flat_spec_i = 0;
   logic [3:0] sel_i = 0;
   logic [31:0] dat_i = 0, dat_o, tex_addr_o, q, base, seed = 32'hA8969731;
   logic [31:0] stip [32];
   logic [9:0] pix_x_i = 0, pix_y_i = 0, out_x_o, out_y_o;
   logic [15:0] out_rgb_o, out_spec_o;
   logic [4:0] out_a_o, out_fog_o;
   logic ack_o, pix_ready_o, out_valid_o, out_ready_i, tex_sysmem_o;
   int miscompares = 0, check_count = 0, ctl = 0, aref = 0, npass = 0, ndrop = 0;
   int bay [16] = '{0, 8, 2, 10, 12, 4, 14, 6, 3, 11, 1, 9, 15, 7, 13, 5};
   exp_t eq [$];
   exp_t me;
   always #5 clk_i = ~clk_i;
   pix_back dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .pix_valid_i(pix_valid_i), .pix_ready_o(pix_ready_o), .pix_x_i(pix_x_i),
      .pix_y_i(pix_y_i), .smooth_rgb_i(smooth_rgb_i), .smooth_a_i(smooth_a_i),
      .smooth_fog_i(smooth_fog_i), .smooth_spec_i(smooth_spec_i), .flat_rgb_i(flat_rgb_i),
      .flat_a_i(flat_a_i), .flat_fog_i(flat_fog_i), .flat_spec_i(flat_spec_i),
      .out_valid_o(out_valid_o), .out_ready_i(out_ready_i), .out_x_o(out_x_o),
      .out_y_o(out_y_o), .out_rgb_o(out_rgb_o), .out_a_o(out_a_o), .out_fog_o(out_fog_o),
      .out_spec_o(out_spec_o), .tex_u_i(tex_u_i), .tex_v_i(tex_v_i),
      .tex_addr_o(tex_addr_o), .tex_sysmem_o(tex_sysmem_o));
   pix_sink sink_u (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall), .ready_o(out_ready_i));
   // ******************************
   // reference model
   // ******************************
   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   // saturate so a bright value never wraps to dark
   function automatic int red(int v, int w, int d);
      int s;
      s = v + (d >> (w - 4));
      return (s > 255 ? 255 : s) >> (8 - w);
   endfunction : red
   function automatic logic [15:0] pk(logic [23:0] c, int d);
      return {5'(red(c[23:16], 5, d)), 6'(red(c[15:8], 6, d)), 5'(red(c[7:0], 5, d))};
   endfunction : pk
   function automatic bit cmp(int f, int a, int r);
      bit [7:0] t;
      t = {1'b1, a >= r, a != r, a > r, a <= r, a == r, a < r, 1'b0};
      return t[f];
   endfunction : cmp
   task automatic check(string nm, logic [63:0] s, logic [63:0] e);
      check_count++;
      if (s !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask : check
   task automatic results();
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : results
   task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= 4'hF;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack_o !== 1'b1);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      check("wb_ack", k, 2);
   endtask : wb
   // expected result of the pixel accepted at this edge
   task automatic push();
      exp_t e;
      int d, a, f;
      logic [23:0] cr, sp;
      d = ctl[4] ? bay[pix_y_i[1:0] * 4 + pix_x_i[1:0]] : 0;
      a = ctl[6] ? smooth_a_i : flat_a_i;
      f = ctl[7] ? smooth_fog_i : flat_fog_i;
      sp = ctl[8] ? smooth_spec_i : flat_spec_i;
      cr = ctl[9] ? smooth_rgb_i : flat_rgb_i;
      e.blk = ctl[5] && !stip[pix_y_i[4:0]][pix_x_i[4:0]];
      // a black pixel carries no dither on any component
      if (e.blk) begin
         d = 0;
         cr = 24'h00_0000;
         sp = 24'h00_0000;
      end
      e.xyc = {pix_x_i, pix_y_i, pk(cr, d)};
      e.afs = {5'(red(a, 5, d)), 5'(red(f, 5, d)), pk(sp, d)};
      e.tex = base + {15'h0, tex_v_i[7:4], tex_u_i[7:4], tex_v_i[3:0], tex_u_i[3:0], 1'b0};
      if (!ctl[0] || cmp(ctl[3:1], a, aref)) begin
         eq.push_back(e);
         npass++;
      end else begin
         ndrop++;
      end
   endtask : push
   // every output handshake must match the oldest expected pixel
   always @(posedge clk_i) begin
      if (!rst_i && out_valid_o && out_ready_i) begin
         if (eq.size() == 0) begin
            check("extra_pixel", 1, 0);
         end else begin
            me = eq.pop_front();
            check("xy_rgb", {out_x_o, out_y_o, out_rgb_o}, me.xyc);
            check("a_fog_spec", {out_a_o, out_fog_o, out_spec_o}, me.afs);
            check("tex_addr", tex_addr_o, me.tex);
         end
      end
   end
   task automatic burst(int cnt);
      int m;
      m = 0;
      while (m < cnt || pix_valid_i) begin
         @(posedge clk_i);
         if (pix_valid_i && pix_ready_o) begin
            push();
            m++;
         end
         if (!pix_valid_i || pix_ready_o) begin
            pix_valid_i <= m < cnt && (rnd() & 3) != 0;
            pix_x_i <= 10'(rnd());
            pix_y_i <= 10'(rnd());
            smooth_a_i <= (rnd() & 1) ? 8'(aref) : 8'(rnd());
            flat_a_i <= (rnd() & 1) ? 8'(aref) : 8'(rnd());
            smooth_fog_i <= 8'(rnd());
            flat_fog_i <= 8'(rnd());
            smooth_rgb_i <= 24'(rnd());
            flat_rgb_i <= 24'(rnd());
            smooth_spec_i <= 24'(rnd());
            flat_spec_i <= 24'(rnd());
            tex_u_i <= 8'(rnd());
            tex_v_i <= 8'(rnd());
         end
      end
      repeat (8) @(posedge clk_i);
      check("drained", eq.size(), 0);
   endtask : burst
   initial begin
      repeat (20000) @(posedge clk_i);
      miscompares++;
      results();
   end
   initial begin
      foreach (stip[i]) stip[i] = 32'h0;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, CTRL_OFS, 32'h0);
      check("ctrl_rst", q, 32'h0);
      wb(1'b0, AREF_OFS, 32'h0);
      check("aref_rst", q, 32'h0);
      wb(1'b0, STIP_OFS, 32'h0);
      check("stip_rst", q, 32'h0);
      wb(1'b0, 8'h40, 32'h0);
      check("unmapped", q, 32'h0);
      wb(1'b1, AREF_OFS, 32'hFFFF_FFFF);
      wb(1'b0, AREF_OFS, 32'h0);
      check("aref_w", q, 32'h0000_00FF);
      base = rnd();
      wb(1'b1, TEXB_OFS, base);
      for (int g = 0; g < 26; g++) begin
         if (g == 9) begin
            for (int r = 0; r < 32; r++) begin
               stip[r] = rnd();
               wb(1'b1, STIP_OFS + 8'(r * 4), stip[r]);
            end
         end
         ctl = rnd() & 32'h3FF;
         ctl[3:1] = g;
         ctl[0] = g < 16;
         if (g == 0) begin
            ctl = 32'h20;
         end
         aref = (g % 5 == 0) ? 255 : rnd() & 255;
         stall <= 1'(g % 2);
         wb(1'b1, CTRL_OFS, ctl);
         wb(1'b1, AREF_OFS, aref);
         burst(12);
      end
      wb(1'b0, STAT_OFS, 32'h0);
      check("stat", q, {16'(npass), 16'(ndrop)});
      check("sysmem", tex_sysmem_o, 1'b1);
      results();
   end
endmodule : pix_back_tb
